// ---- dv/host_spi_master.sv ----
// host model: drives select and serial clock, collects the word
// assumes the device floats its data pin while its enable is high
`timescale 1ns/1ps
module host_spi_master #(
    parameter int HALF_NS = 80,
    parameter int LEAD_NS = 400,
    parameter int GAP_NS = 400
) (
    output logic select_n_input,
    output logic serial_clock,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n
);
    logic last_r = 1'b0;
    logic line;
    // a released pin shows the inverse of its last driven level
    assign line = serial_data_oe_n ? ~last_r : serial_data_out;
    always @(serial_data_out, serial_data_oe_n) if (!serial_data_oe_n) last_r = serial_data_out;
    initial begin
        select_n_input = 1'b1;
        serial_clock = 1'b0;
    end
    task automatic idle_clocks(output logic seen);
        seen = 1'b1;
        repeat (4) begin
            serial_clock = 1'b1;
            #HALF_NS;
            serial_clock = 1'b0;
            #HALF_NS;
            seen = seen & serial_data_oe_n;
        end
    endtask
    task automatic frame(input int n, input bit hi, input int extra,
                         output logic [15:0] w, output logic [1:0] lead, output logic oe_end);
        w = '0;
        #3;
        serial_clock = hi; // low at select fall unless an error is wanted
        #HALF_NS;
        select_n_input = 1'b0;
        #HALF_NS;
        serial_clock = 1'b0;
        #LEAD_NS; // lead and standby enable delay
        lead = {serial_data_oe_n, line};
        repeat (n) begin // count of clocks
            serial_clock = 1'b1;
            #HALF_NS;
            serial_clock = 1'b0;
            #HALF_NS;
            w = {w[14:0], line}; // first bit lands on top
        end
        #extra;
        oe_end = serial_data_oe_n;
        select_n_input = 1'b1;
        #GAP_NS; // inter-frame gap
    endtask
endmodule

// ---- dv/test_status_register_spi_readout.sv ----
// bench: host model runs frames, a word model checks each read whose mask is not negative
// assumes the package and the readout module are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_status_register_spi_readout
    import status_spi_pkg::*;
;
    localparam int POS[8] = '{BIT_WAKE, BIT_GUARD, BIT_BUS_ERR, BIT_TEMP_HIGH, BIT_TX_TIMEOUT, BIT_VCC_UV,
        BIT_VIO_UV, BIT_TEMP_WARN};
    localparam int BAD_N[4] = '{15, 17, 16, 16};
    logic ref_clk, resetn, host_standby_command_n, normal_mode, mode_change, bus_active, seen;
    logic select_n_input, serial_clock, serial_data_out, serial_data_oe_n, error_indication_n;
    logic [7:0] cond;
    logic [15:0] status_word;
    int mismatches, num_checks, cycles;
    int unsigned r;
    status_register_spi_readout #(.TIMEOUT_CYC(200)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
        .select_n_input(select_n_input), .serial_clock(serial_clock), .serial_data_out(serial_data_out),
        .serial_data_oe_n(serial_data_oe_n), .host_standby_command_n(host_standby_command_n),
        .normal_mode(normal_mode), .mode_change(mode_change), .bus_active(bus_active), .wake_event(cond[0]),
        .guard_err(cond[1]), .bus_err(cond[2]), .temp_high(cond[3]), .tx_timeout(cond[4]), .vcc_uv(cond[5]),
        .vio_uv(cond[6]), .temp_warn(cond[7]), .error_indication_n(error_indication_n),
        .status_word(status_word));
    host_spi_master u_host (.select_n_input(select_n_input), .serial_clock(serial_clock),
        .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // expected word: low mask marks flags that are set
    function automatic logic [15:0] expw(input logic [15:0] lowm);
        logic [15:0] w;
        w = 16'h3fff & ~lowm;
        w[BIT_MODE] = normal_mode;
        w[BIT_ACTIVITY] = ~bus_active;
        w[BIT_PARITY] = ~(^w[14:0]);
        return w;
    endfunction
    task automatic wrap_up();
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // lowm below zero: word not compared
    task automatic rd(input int lowm, input int n = 16, input bit hi = 1'b0, input int extra = 0);
        logic [15:0] w;
        logic [1:0] ld;
        logic oe;
        @(posedge ref_clk);
        u_host.frame(n, hi, extra, w, ld, oe);
        if (cond[6]) `CHK(ld[1], 1'b1)
        else begin
            `CHK(ld, 2'b00)
            `CHK(oe, extra > 0)
        end
        if (lowm >= 0) `CHK(w, expw(lowm[15:0]))
        repeat (6) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        resetn = 1'b0;
        host_standby_command_n = 1'b1;
        normal_mode = 1'b1;
        mode_change = 1'b0;
        bus_active = 1'b0;
        cond = 8'h00;
        r = $urandom(32'hbabe);
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        `CHK(status_word, expw(16'h0010))
        rd(16'h0010);
        rd(0);
        u_host.idle_clocks(seen);
        `CHK(seen, 1'b1)
        @(posedge ref_clk);
        repeat (8) begin
            bus_active <= 1'($urandom);
            normal_mode <= 1'($urandom);
            rd(0);
        end
        for (int i = 0; i < 8; i++) begin
            cond[i] <= 1'b1;
            host_standby_command_n <= 1'(i != 3);
            rd(i == 6 ? -1 : (1 << POS[i]) | ((i > 0 && i < 6) ? 16'h1000 : 0));
            if (i > 0 && i < 6) `CHK(error_indication_n, !host_standby_command_n)
            cond[i] <= 1'b0;
            @(posedge ref_clk);
            mode_change <= 1'b1;
            @(posedge ref_clk);
            mode_change <= 1'b0;
            repeat (4) @(posedge ref_clk);
            rd(0);
            `CHK(error_indication_n, 1'b1)
        end
        for (int k = 0; k < 4; k++) begin
            rd(-1, BAD_N[k], k == 2, k == 3 ? 3000 : 0);
            rd(16'h1400);
            rd(0);
        end
        wrap_up();
    end
endmodule

// ---- shared/status_spi_pkg.sv ----
// package: constants for the status word serial read-out
// assumes 50 MHz ref_clk; serial pins are asynchronous to it
package status_spi_pkg;
    localparam int CLK_MHZ = 50;
    localparam int WORD_BITS = 16;
    localparam logic [4:0] FRAME_CLOCKS = 5'h10;
    // status word bit positions
    localparam int BIT_WAKE = 0;
    localparam int BIT_MODE = 1;
    localparam int BIT_GUARD = 2;
    localparam int BIT_ACTIVITY = 3;
    localparam int BIT_POWER_ON = 4;
    localparam int BIT_BUS_ERR = 5;
    localparam int BIT_TEMP_HIGH = 6;
    localparam int BIT_TX_TIMEOUT = 7;
    localparam int BIT_VCC_UV = 8;
    localparam int BIT_VIO_UV = 9;
    localparam int BIT_PORT_ERR = 10;
    localparam int BIT_TEMP_WARN = 11;
    localparam int BIT_ERROR = 12;
    localparam int BIT_RSV_HIGH = 13;
    localparam int BIT_RSV_LOW = 14;
    localparam int BIT_PARITY = 15;
    // latched flags reset inactive (high) at power-on: only power-on flag set (low)
    localparam logic [15:0] LATCH_RESET = 16'hffef;
    // read-out timeout in microseconds and its cycle count
    // must outlast 16 clocks at the slowest serial rate
    localparam int SELECT_LOW_TIMEOUT_US = 2000;
    localparam int SELECT_LOW_TIMEOUT_CYC = SELECT_LOW_TIMEOUT_US * CLK_MHZ;
    localparam int TIMER_W = 17;
endpackage

// ---- verilog/pin_sync.sv ----
// two-flop synchroniser for asynchronous pins, with edge pulses
// assumes one clock domain ref_clk
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= RESET_LEVEL;
            sync_r <= RESET_LEVEL;
            last_r <= RESET_LEVEL;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~last_r;
    assign fall = ~sync_r & last_r;
endmodule

// ---- verilog/status_register_spi_readout.sv ----
// top: read-only serial port shifting the 16-bit status word
// assumes host drives select_n_input and serial clock; flag events are
// level inputs from surrounding logic in the ref_clk domain
`timescale 1ns/1ps
module status_register_spi_readout
    import status_spi_pkg::*;
#(
    parameter int TIMEOUT_CYC = SELECT_LOW_TIMEOUT_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic select_n_input,
    input wire logic serial_clock,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    input wire logic host_standby_command_n,
    input wire logic normal_mode,
    input wire logic mode_change,
    input wire logic bus_active,
    input wire logic wake_event,
    input wire logic guard_err,
    input wire logic bus_err,
    input wire logic temp_high,
    input wire logic tx_timeout,
    input wire logic vcc_uv,
    input wire logic vio_uv,
    input wire logic temp_warn,
    output logic error_indication_n,
    output logic [15:0] status_word
);
    logic sel_n;
    logic sel_rise;
    logic sel_fall;
    logic sclk;
    logic sclk_rise;
    logic sclk_fall;

    pin_sync #(.RESET_LEVEL(1'b1)) u_sel (
        .ref_clk(ref_clk), .resetn(resetn), .pin(select_n_input),
        .level(sel_n), .rise(sel_rise), .fall(sel_fall)
    );
    // 50 MHz sampling leaves several cycles per half period at 4 MHz
    pin_sync #(.RESET_LEVEL(1'b0)) u_sclk (
        .ref_clk(ref_clk), .resetn(resetn), .pin(serial_clock),
        .level(sclk), .rise(sclk_rise), .fall(sclk_fall)
    );

    // latched active-low flags (bits 0,2,4..12 used)
    logic [15:0] latch_r;
    logic [15:0] shift_r;
    logic [4:0] count_r;
    logic [TIMER_W-1:0] timer_r;
    logic active_r;
    logic bad_r;
    logic timed_out_r;

    // live conditions, active low
    logic [15:0] cond_n;
    always_comb begin
        cond_n = 16'hffff;
        cond_n[BIT_WAKE] = ~wake_event;
        cond_n[BIT_GUARD] = ~guard_err;
        cond_n[BIT_BUS_ERR] = ~bus_err;
        cond_n[BIT_TEMP_HIGH] = ~temp_high;
        cond_n[BIT_TX_TIMEOUT] = ~tx_timeout;
        cond_n[BIT_VCC_UV] = ~vcc_uv;
        cond_n[BIT_VIO_UV] = ~vio_uv;
        cond_n[BIT_TEMP_WARN] = ~temp_warn;
    end

    // assemble status word
    logic [15:0] word;
    always_comb begin
        word = latch_r;
        word[BIT_MODE] = normal_mode;
        word[BIT_ACTIVITY] = ~bus_active;
        word[BIT_ERROR] = &{latch_r[BIT_GUARD], latch_r[BIT_BUS_ERR], latch_r[BIT_TEMP_HIGH],
            latch_r[BIT_TX_TIMEOUT], latch_r[BIT_VCC_UV], latch_r[BIT_VIO_UV],
            latch_r[BIT_PORT_ERR], latch_r[BIT_ERROR]};
        word[BIT_RSV_HIGH] = 1'b1;
        word[BIT_RSV_LOW] = 1'b0;
        word[BIT_PARITY] = ~(^word[14:0]);
    end

    logic frame_end;
    logic good_end;
    logic bad_end;
    assign frame_end = active_r & (sel_rise | timed_out_r);
    assign good_end = active_r & sel_rise & ~bad_r & ~timed_out_r & (count_r == FRAME_CLOCKS);
    assign bad_end = frame_end & ~good_end;

    // frame control; select ignored under logic undervoltage
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            active_r <= 1'b0;
            bad_r <= 1'b0;
        end else if (sel_fall && !vio_uv) begin
            active_r <= 1'b1;
            bad_r <= sclk;
        end else if (frame_end || sel_n || vio_uv) begin
            active_r <= 1'b0;
        end
    end

    // read-out timer from select fall
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            timer_r <= '0;
            timed_out_r <= 1'b0;
        end else if (sel_fall) begin
            timer_r <= '0;
            timed_out_r <= 1'b0;
        end else if (active_r && !timed_out_r) begin
            if (timer_r == TIMER_W'(TIMEOUT_CYC - 1)) begin
                timed_out_r <= 1'b1;
            end
            timer_r <= timer_r + 1'b1;
        end
    end

    // shifter: load on select fall, advance on serial clock rise
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            shift_r <= '0;
            count_r <= '0;
        end else if (sel_fall) begin
            shift_r <= word;
            count_r <= '0;
        end else if (active_r && sclk_rise) begin
            if (count_r != 5'h1f) begin
                count_r <= count_r + 1'b1;
            end
            // first rise only opens the word: bit 15 must stand before any shift
            if (count_r != 5'h0) begin
                shift_r <= {shift_r[14:0], 1'b0};
            end
        end
    end

    // output pin: low before first clock, then msb; float otherwise
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            serial_data_out <= 1'b0;
            serial_data_oe_n <= 1'b1;
        end else if (active_r && !timed_out_r && !sel_n) begin
            serial_data_oe_n <= 1'b0;
            serial_data_out <= (count_r == 5'h0) ? 1'b0 : shift_r[15];
        end else begin
            serial_data_oe_n <= 1'b1;
            serial_data_out <= 1'b0;
        end
    end

    // latched flags: set wins over clear
    logic clear_ok;
    assign clear_ok = good_end | mode_change;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            latch_r <= LATCH_RESET;
        end else begin
            for (int i = 0; i < WORD_BITS; i++) begin
                if (!cond_n[i]) begin
                    latch_r[i] <= 1'b0;
                end else if (clear_ok) begin
                    latch_r[i] <= 1'b1;
                end
            end
            if (vio_uv) begin
                latch_r[BIT_ERROR] <= 1'b0;
            end else if (clear_ok) begin
                latch_r[BIT_ERROR] <= 1'b1;
            end
            if (bad_end) begin
                latch_r[BIT_PORT_ERR] <= 1'b0;
                latch_r[BIT_ERROR] <= 1'b0;
            end else if (clear_ok) begin
                latch_r[BIT_PORT_ERR] <= 1'b1;
            end
        end
    end

    // error pin refreshes on correct read or mode change; visible word every cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            error_indication_n <= 1'b1;
            status_word <= LATCH_RESET;
        end else begin
            status_word <= word;
            if (good_end || mode_change) begin
                error_indication_n <= ~(~word[BIT_ERROR] & host_standby_command_n);
            end
        end
    end

    a_float_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
        sel_n |=> serial_data_oe_n) else $error("output driven while deselected");
    a_drive_low: assert property (@(posedge ref_clk) disable iff (!resetn)
        (sel_fall && !vio_uv) ##1 (!sel_n && count_r == 5'h0) |=> (!serial_data_oe_n && !serial_data_out))
        else $error("output not low at frame start");
    a_timeout_rel: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(timed_out_r) |=> serial_data_oe_n) else $error("output not released on timeout");
    a_bad_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
        bad_end |=> (!latch_r[BIT_PORT_ERR] && !latch_r[BIT_ERROR])) else $error("error flags not set");
    a_edge_error: assert property (@(posedge ref_clk) disable iff (!resetn)
        (sel_fall && sclk && !vio_uv) |=> bad_r) else $error("clock high at select fall missed");
    a_parity: assert property (@(posedge ref_clk) disable iff (!resetn)
        status_word[BIT_PARITY] == ~(^status_word[14:0])) else $error("parity wrong");
    a_sum_error: assert property (@(posedge ref_clk) disable iff (!resetn)
        !latch_r[BIT_BUS_ERR] |-> !word[BIT_ERROR]) else $error("summary error missing");
    a_uv_block: assert property (@(posedge ref_clk) disable iff (!resetn)
        vio_uv ##1 vio_uv |-> !active_r) else $error("access under undervoltage");
    a_latch_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!latch_r[BIT_WAKE] && !clear_ok) |=> !latch_r[BIT_WAKE]) else $error("wake flag lost");

    c_good_read: cover property (@(posedge ref_clk) disable iff (!resetn) good_end);
    c_bad_read: cover property (@(posedge ref_clk) disable iff (!resetn) bad_end);
    c_timeout: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(timed_out_r));
endmodule
